// ==== core/etw_dev.sv ====
// Memory device end: two-wire slave with write buffer and nonvolatile array.
// Function
// - Acknowledge memory command 17h unless programming.
// - Acknowledge the location byte after command.
// - Acknowledge every data byte; STOP ends write.
// - Eight-byte wrapping buffer keeps last eight.
// - Program buffered bytes only on STOP.
// - START instead of STOP discards buffered data.
// - Master waits out the programming time; the host instead retries refused commands at once.
// - Refuse command byte while programming runs.
// - Master repeats refused transaction from START.
// - Repeated START, read address, then send data.
// - Master acknowledges all but final read byte.
// - Read location advances after each byte.
module etw_dev #(
  parameter logic [6:0]  DEV_ADDR  = etw_pkg::DEV_ADDR_DEF,
  parameter int unsigned WR_CYCLES = etw_pkg::WR_CYCLES_DEF
) (
  input  logic clock,
  input  logic srst,
  input  logic link_clk,
  input  logic link_srst,
  output logic prog_busy,
  output logic prog_done,
  etw_if.dev   bus
);
  import etw_pkg::*;

  logic scl_s1, scl_s2, scl_s3;   // Clock line synchroniser and history.
  logic sda_s1, sda_s2, sda_s3;   // Data line synchroniser and history.
  logic scl_rise, scl_fall;       // Clock edges seen on the link.
  logic start_seen, stop_seen;    // Bus conditions seen on the link.

  etw_dst_t st, next_st;          // Bit-level state.
  etw_ph_t  ph, next_ph;          // Byte expected next.
  logic [3:0] cnt, next_cnt;      // Bit counter and ack sub-phase.
  logic [7:0] sh, next_sh;        // Shift register for both directions.
  logic [7:0] loc, next_loc;      // Current memory location.
  logic [7:0] base, next_base;    // Location given for a write.
  logic [2:0] ptr, next_ptr;      // Write buffer slot.
  logic [BUF_DEPTH-1:0] vld, next_vld;  // Slots written in this transfer.
  logic drv, next_drv;            // Device pulls data low.
  logic busy, next_busy;          // Programming cycle running.
  logic done_tgl, next_done_tgl;  // Toggles when programming ends.
  logic [TMR_W-1:0] tmr, next_tmr;  // Programming timer.
  logic buf_we;                   // Store received byte in buffer.
  logic commit;                   // Copy buffer into the array.
  logic ack;                      // Acknowledge the byte just received.
  logic [7:0] byte_in;            // Byte completed by this rising edge.
  logic [7:0] tx_byte;            // Byte to send next.

  logic [7:0] mem [MEM_BYTES];    // Nonvolatile array.
  logic [7:0] wbuf [BUF_DEPTH];   // Write buffer.

  logic busy_s1, busy_s2;         // Busy level into the system domain.
  logic tgl_s1, tgl_s2, tgl_s3;   // Done toggle into the system domain.
  logic next_prog_done;           // Done pulse before its register.

  // Two flops per line before any logic looks at them; third for edges.
  always_ff @(posedge link_clk) begin
    if (link_srst) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_s3 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_s3 <= 1'b1;
    end else begin
      scl_s1 <= bus.scl;
      scl_s2 <= scl_s1;
      scl_s3 <= scl_s2;
      sda_s1 <= bus.sda;
      sda_s2 <= sda_s1;
      sda_s3 <= sda_s2;
    end
  end

  assign scl_rise   = scl_s2 && !scl_s3;
  assign scl_fall   = !scl_s2 && scl_s3;
  // Data moving while the clock stays high marks START or STOP.
  assign start_seen = scl_s2 && scl_s3 && !sda_s2 && sda_s3;
  assign stop_seen  = scl_s2 && scl_s3 && sda_s2 && !sda_s3;
  assign byte_in    = {sh[6:0], sda_s2};
  assign tx_byte    = mem[loc];

  // Protocol engine next-state logic.
  always_comb begin
    next_st       = st;
    next_ph       = ph;
    next_cnt      = cnt;
    next_sh       = sh;
    next_loc      = loc;
    next_base     = base;
    next_ptr      = ptr;
    next_vld      = vld;
    next_drv      = drv;
    next_busy     = busy;
    next_tmr      = tmr;
    next_done_tgl = done_tgl;
    buf_we        = 1'b0;
    commit        = 1'b0;
    ack           = 1'b0;
    // The timer runs on its own; the bus keeps working meanwhile.
    if (busy) begin
      if (tmr == TMR_W'(WR_CYCLES - 1)) begin
        next_busy     = 1'b0;
        next_tmr      = '0;
        next_done_tgl = !done_tgl;
      end else begin
        next_tmr = tmr + 1'b1;
      end
    end
    if (start_seen) begin
      // Any START restarts decoding and drops an unfinished write.
      next_st  = DS_RX;
      next_ph  = PH_ADDR;
      next_cnt = '0;
      next_drv = 1'b0;
      next_vld = '0;
    end else if (stop_seen) begin
      next_st  = DS_WAIT;
      next_drv = 1'b0;
      // Only a write that delivered data starts programming.
      if (ph == PH_DATA && |vld) begin
        commit    = 1'b1;
        next_busy = 1'b1;
        next_tmr  = '0;
        next_vld  = '0;
      end
    end else begin
      unique case (st)
        DS_WAIT: begin
          // Not addressed or refused: stay off the bus until START.
        end
        DS_RX: begin
          if (scl_rise) begin
            next_sh  = byte_in;
            next_cnt = cnt + 4'd1;
            if (cnt == 4'd7) begin
              next_cnt = '0;
              unique case (ph)
                PH_ADDR: begin
                  ack = byte_in[7:1] == DEV_ADDR;
                  // A read address keeps the phase so the ack knows to send.
                  if (!byte_in[0]) begin
                    next_ph = PH_CMD;
                  end
                end
                PH_CMD: begin
                  ack     = byte_in == CMD_MEM && !busy;
                  next_ph = PH_LOC;
                end
                PH_LOC: begin
                  ack       = 1'b1;
                  next_loc  = byte_in;
                  next_base = byte_in;
                  next_ptr  = byte_in[2:0];
                  next_vld  = '0;
                  next_ph   = PH_DATA;
                end
                PH_DATA: begin
                  ack           = 1'b1;
                  buf_we        = 1'b1;
                  next_vld[ptr] = 1'b1;
                  next_ptr      = ptr + 3'd1;
                end
              endcase
              next_st = ack ? DS_ACK : DS_WAIT;
            end
          end
        end
        DS_ACK: begin
          // First falling edge drives the ack, the second ends it.
          if (scl_fall) begin
            if (cnt == 4'd0) begin
              next_drv = 1'b1;
              next_cnt = 4'd1;
            end else if (ph == PH_ADDR) begin
              next_sh  = tx_byte;
              next_loc = loc + 8'd1;
              next_drv = !tx_byte[7];
              next_cnt = '0;
              next_st  = DS_TX;
            end else begin
              next_drv = 1'b0;
              next_cnt = '0;
              next_st  = DS_RX;
            end
          end
        end
        DS_TX: begin
          // Bits change on falling edges so they are stable while high.
          if (scl_rise) begin
            next_cnt = cnt + 4'd1;
          end
          if (scl_fall) begin
            if (cnt == 4'd8) begin
              next_drv = 1'b0;
              next_cnt = '0;
              next_st  = DS_RACK;
            end else begin
              next_drv = !sh[3'd7 - cnt[2:0]];
            end
          end
        end
        DS_RACK: begin
          // A not-acknowledge ends the read; the master then stops.
          if (scl_rise) begin
            if (sda_s2) begin
              next_st = DS_WAIT;
            end else begin
              next_cnt = 4'd1;
            end
          end
          if (scl_fall && cnt == 4'd1) begin
            next_sh  = tx_byte;
            next_loc = loc + 8'd1;
            next_drv = !tx_byte[7];
            next_cnt = '0;
            next_st  = DS_TX;
          end
        end
      endcase
    end
  end

  // Protocol engine registers.
  always_ff @(posedge link_clk) begin
    if (link_srst) begin
      st       <= DS_WAIT;
      ph       <= PH_ADDR;
      cnt      <= '0;
      sh       <= '0;
      loc      <= '0;
      base     <= '0;
      ptr      <= '0;
      vld      <= '0;
      drv      <= 1'b0;
      busy     <= 1'b0;
      done_tgl <= 1'b0;
      tmr      <= '0;
    end else begin
      st       <= next_st;
      ph       <= next_ph;
      cnt      <= next_cnt;
      sh       <= next_sh;
      loc      <= next_loc;
      base     <= next_base;
      ptr      <= next_ptr;
      vld      <= next_vld;
      drv      <= next_drv;
      busy     <= next_busy;
      done_tgl <= next_done_tgl;
      tmr      <= next_tmr;
    end
  end

  // Buffer and array writes. The whole group lands in one cycle, so a
  // read that follows programming always sees the new bytes.
  always_ff @(posedge link_clk) begin
    if (buf_we) begin
      wbuf[ptr] <= byte_in;
    end
    if (commit) begin
      for (int i = 0; i < BUF_DEPTH; i++) begin
        if (vld[i]) begin
          mem[{base[7:3], 3'(i)}] <= wbuf[i];
        end
      end
    end
  end

  assign bus.d_sda_o  = 1'b0;
  assign bus.d_sda_oe = drv;

  // Status into the system domain: level by two flops, event by toggle.
  always_comb begin
    next_prog_done = tgl_s2 ^ tgl_s3;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      busy_s1   <= 1'b0;
      busy_s2   <= 1'b0;
      tgl_s1    <= 1'b0;
      tgl_s2    <= 1'b0;
      tgl_s3    <= 1'b0;
      prog_done <= 1'b0;
    end else begin
      busy_s1   <= busy;
      busy_s2   <= busy_s1;
      tgl_s1    <= done_tgl;
      tgl_s2    <= tgl_s1;
      tgl_s3    <= tgl_s2;
      prog_done <= next_prog_done;
    end
  end

  assign prog_busy = busy_s2;
endmodule

// ==== core/etw_fifo.sv ====
// Synchronous FIFO with valid and ready on both sides.
module etw_fifo #(
  parameter int W = 8,   // Word width.
  parameter int D = 16   // Depth; must be a power of two.
) (
  input  logic         clock,
  input  logic         srst,
  input  logic         in_valid,
  output logic         in_ready,
  input  logic [W-1:0] in_data,
  output logic         out_valid,
  input  logic         out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem [D];          // Storage words.
  logic [AW:0]  wp, next_wp;      // Write pointer with wrap bit.
  logic [AW:0]  rp, next_rp;      // Read pointer with wrap bit.

  // Full when the pointers differ by exactly the depth.
  assign in_ready  = (wp - rp) != (AW+1)'(D);
  assign out_valid = wp != rp;
  assign out_data  = mem[rp[AW-1:0]];

  // Pointers advance only on a completed handshake.
  always_comb begin
    next_wp = wp + (AW+1)'(in_valid && in_ready);
    next_rp = rp + (AW+1)'(out_valid && out_ready);
  end

  // Register pointers; storage is not reset since pointers gate it.
  always_ff @(posedge clock) begin
    if (srst) begin
      wp <= '0;
      rp <= '0;
    end else begin
      wp <= next_wp;
      rp <= next_rp;
    end
    if (in_valid && in_ready) begin
      mem[wp[AW-1:0]] <= in_data;
    end
  end
endmodule

// ==== core/etw_host.sv ====
// Bus master end: runs memory writes and reads over the two-wire link.
module etw_host #(
  parameter logic [6:0] DEV_ADDR = etw_pkg::DEV_ADDR_DEF,
  parameter int         QTR      = etw_pkg::SCL_QTR
) (
  input  logic       clock,
  input  logic       srst,
  input  logic       cmd_valid,
  output logic       cmd_ready,
  input  logic       cmd_read,
  input  logic [7:0] cmd_loc,
  input  logic [7:0] cmd_len,
  input  logic       wr_valid,
  output logic       wr_ready,
  input  logic [7:0] wr_data,
  output logic       rd_valid,
  output logic [7:0] rd_data,
  output logic       done,
  etw_if.host        bus
);
  import etw_pkg::*;

  etw_hst_t  st, next_st;          // Bit-level state.
  etw_step_t step, next_step;      // Byte of the transaction in flight.
  logic [15:0] div, next_div;      // Quarter-period divider.
  logic [1:0]  q, next_q;          // Quarter within a bit slot.
  logic [3:0]  bitn, next_bitn;    // Slot within a byte, 8 is the ack.
  logic [7:0]  sh, next_sh;        // Byte being shifted.
  logic [7:0]  loc, next_loc;      // Location of the command.
  logic [7:0]  left, next_left;    // Data bytes still to move.
  logic rd, next_rd;               // Command is a read.
  logic nack, next_nack;           // Last byte sent was refused.
  logic retry, next_retry;         // Start over after this STOP.
  logic next_rd_valid, next_done;  // Pulses before their registers.
  logic [7:0] next_rd_data;        // Read byte before its register.
  logic scl_oe, next_scl_oe;       // Clock pulled low.
  logic sda_oe, next_sda_oe;       // Data pulled low.
  logic sda_s1, sda_s2;            // Data line synchroniser.
  logic tick, slot_end;            // Quarter and slot boundaries.
  logic f_valid, f_pop;            // FIFO output handshake.
  logic [7:0] f_data;              // FIFO output word.

  // Write data waits here; a stalled link fills it and stops the source.
  etw_fifo #(.W(8), .D(FIFO_DEPTH)) etw_fifo_inst (
    .clock    (clock),
    .srst     (srst),
    .in_valid (wr_valid),
    .in_ready (wr_ready),
    .in_data  (wr_data),
    .out_valid(f_valid),
    .out_ready(f_pop),
    .out_data (f_data)
  );

  assign tick      = div == 16'(QTR - 1);
  assign slot_end  = tick && q == 2'd3;
  assign cmd_ready = st == HS_IDLE;

  // Sequencer next-state logic.
  always_comb begin
    next_st       = st;
    next_step     = step;
    next_div      = tick ? '0 : div + 16'd1;
    next_q        = tick ? q + 2'd1 : q;
    next_bitn     = bitn;
    next_sh       = sh;
    next_loc      = loc;
    next_left     = left;
    next_rd       = rd;
    next_nack     = nack;
    next_retry    = retry;
    next_rd_valid = 1'b0;
    next_rd_data  = rd_data;
    next_done     = 1'b0;
    f_pop         = 1'b0;
    unique case (st)
      HS_IDLE: begin
        // Restart the divider so the first low phase of a frame is a full quarter.
        next_q   = '0;
        next_div = '0;
        if (cmd_valid) begin
          next_st   = HS_START;
          next_step = ST_ADDRW;
          next_rd   = cmd_read;
          next_loc  = cmd_loc;
          next_left = cmd_len;
        end
      end
      HS_START: begin
        if (slot_end) begin
          next_sh   = {DEV_ADDR, step == ST_ADDRR};
          next_bitn = '0;
          next_st   = HS_TX;
        end
      end
      HS_TX: begin
        // Sample the ack in the middle of the high clock phase.
        if (tick && q == 2'd1 && bitn == 4'd8) begin
          next_nack = sda_s2;
        end
        if (slot_end && bitn != 4'd8) begin
          next_bitn = bitn + 4'd1;
          next_sh   = {sh[6:0], 1'b0};
        end else if (slot_end) begin
          next_bitn = '0;
          if (nack) begin
            // Refused: stop and run the whole transaction again.
            next_retry = 1'b1;
            next_st    = HS_STOP;
          end else begin
            unique case (step)
              ST_ADDRW: begin
                next_step = ST_CMD;
                next_sh   = CMD_MEM;
              end
              ST_CMD: begin
                next_step = ST_LOC;
                next_sh   = loc;
              end
              ST_LOC: begin
                if (rd) begin
                  next_step = ST_ADDRR;
                  next_st   = HS_START;
                end else if (left == 8'd0) begin
                  next_st = HS_STOP;
                end else begin
                  next_step = ST_DATA;
                  next_st   = HS_WAITD;
                end
              end
              ST_DATA: begin
                next_left = left - 8'd1;
                next_st   = left == 8'd1 ? HS_STOP : HS_WAITD;
              end
              ST_ADDRR: begin
                next_step = ST_RDATA;
                next_st   = HS_RX;
              end
              default: begin
                next_st = HS_STOP;
              end
            endcase
          end
        end
      end
      HS_WAITD: begin
        // Hold the clock low until a data byte is available.
        next_q   = '0;
        next_div = '0;
        if (f_valid) begin
          f_pop     = 1'b1;
          next_sh   = f_data;
          next_bitn = '0;
          next_st   = HS_TX;
        end
      end
      HS_RX: begin
        if (tick && q == 2'd1 && bitn != 4'd8) begin
          next_sh = {sh[6:0], sda_s2};
        end
        if (slot_end && bitn != 4'd8) begin
          next_bitn = bitn + 4'd1;
        end else if (slot_end) begin
          next_bitn     = '0;
          next_rd_valid = 1'b1;
          next_rd_data  = sh;
          next_left     = left - 8'd1;
          next_st       = left == 8'd1 ? HS_STOP : HS_RX;
        end
      end
      HS_STOP: begin
        if (slot_end && retry) begin
          next_retry = 1'b0;
          next_step  = ST_ADDRW;
          next_st    = HS_START;
        end else if (slot_end) begin
          next_done = 1'b1;
          next_st   = HS_IDLE;
        end
      end
    endcase
    // Line drive per slot shape; the clock is high in quarters 1 and 2.
    next_scl_oe = q == 2'd0 || q == 2'd3;
    next_sda_oe = 1'b0;
    unique case (st)
      HS_IDLE:  next_scl_oe = 1'b0;
      HS_WAITD: next_scl_oe = 1'b1;
      HS_START: next_sda_oe = q[1];
      HS_STOP: begin
        next_scl_oe = q == 2'd0;
        next_sda_oe = !q[1];
      end
      HS_TX:    next_sda_oe = bitn != 4'd8 && !sh[7];
      HS_RX:    next_sda_oe = bitn == 4'd8 && left != 8'd1;
    endcase
  end

  // Sequencer registers; the data line passes two flops first.
  always_ff @(posedge clock) begin
    if (srst) begin
      st       <= HS_IDLE;
      step     <= ST_ADDRW;
      div      <= '0;
      q        <= '0;
      bitn     <= '0;
      sh       <= '0;
      loc      <= '0;
      left     <= '0;
      rd       <= 1'b0;
      nack     <= 1'b0;
      retry    <= 1'b0;
      rd_valid <= 1'b0;
      rd_data  <= '0;
      done     <= 1'b0;
      scl_oe   <= 1'b0;
      sda_oe   <= 1'b0;
      sda_s1   <= 1'b1;
      sda_s2   <= 1'b1;
    end else begin
      st       <= next_st;
      step     <= next_step;
      div      <= next_div;
      q        <= next_q;
      bitn     <= next_bitn;
      sh       <= next_sh;
      loc      <= next_loc;
      left     <= next_left;
      rd       <= next_rd;
      nack     <= next_nack;
      retry    <= next_retry;
      rd_valid <= next_rd_valid;
      rd_data  <= next_rd_data;
      done     <= next_done;
      scl_oe   <= next_scl_oe;
      sda_oe   <= next_sda_oe;
      sda_s1   <= bus.sda;
      sda_s2   <= sda_s1;
    end
  end

  assign bus.m_scl_o  = 1'b0;
  assign bus.m_scl_oe = scl_oe;
  assign bus.m_sda_o  = 1'b0;
  assign bus.m_sda_oe = sda_oe;
endmodule

// ==== core/etw_if.sv ====
// Open-drain two-wire link between the bus master and the memory device.
interface etw_if;
  logic m_scl_o;   // Master clock output value, always low.
  logic m_scl_oe;  // Master pulls the clock line low.
  logic m_sda_o;   // Master data output value, always low.
  logic m_sda_oe;  // Master pulls the data line low.
  logic d_sda_o;   // Device data output value, always low.
  logic d_sda_oe;  // Device pulls the data line low.
  logic scl;       // Resolved clock line level.
  logic sda;       // Resolved data line level.

  // Wired-AND with pull-ups: any enabled low driver wins.
  assign scl = !(m_scl_oe && !m_scl_o);
  assign sda = !((m_sda_oe && !m_sda_o) || (d_sda_oe && !d_sda_o));

  modport host (output m_scl_o, m_scl_oe, m_sda_o, m_sda_oe, input scl, sda);
  modport dev (output d_sda_o, d_sda_oe, input scl, sda);
endinterface

// ==== core/etw_pkg.sv ====
// Shared constants and state types for the two-wire memory access block.
package etw_pkg;
  localparam int CLK_MHZ        = 250;           // System clock rate in MHz.
  localparam int LINK_PERIOD_NS = 32;            // Device link clock period in ns.
  localparam int SCL_KHZ        = 400;           // Highest serial clock rate in kHz.
  // Quarter of a serial clock period in system cycles, rounded up.
  localparam int SCL_QTR        = (CLK_MHZ * 1000 + 4 * SCL_KHZ - 1) / (4 * SCL_KHZ);
  localparam int T_WR_TYP_MS    = 10;            // Typical programming time in ms.
  localparam int T_WR_MAX_MS    = 50;            // Longest programming time in ms.
  // Programming time in link cycles, rounded down.
  localparam int WR_CYCLES_DEF  = T_WR_TYP_MS * 1000000 / LINK_PERIOD_NS;
  localparam int TMR_W          = 24;            // Width of the programming timer.
  localparam logic [7:0] CMD_MEM = 8'h17;        // Memory access command code.
  localparam int BUF_DEPTH      = 8;             // Bytes held by the write buffer.
  localparam int MEM_BYTES      = 256;           // Size of the nonvolatile array.
  localparam int FIFO_DEPTH     = 16;            // Words in the host write FIFO.
  localparam logic [6:0] DEV_ADDR_DEF = 7'h2a;   // Bus address; value is arbitrary.

  // Device bit-level states.
  typedef enum logic [2:0] {DS_WAIT, DS_RX, DS_ACK, DS_TX, DS_RACK} etw_dst_t;
  // Which byte of the transaction the device expects next.
  typedef enum logic [1:0] {PH_ADDR, PH_CMD, PH_LOC, PH_DATA} etw_ph_t;
  // Host bit-level states.
  typedef enum logic [2:0] {HS_IDLE, HS_START, HS_TX, HS_RX, HS_WAITD, HS_STOP} etw_hst_t;
  // Host transaction steps.
  typedef enum logic [2:0] {ST_ADDRW, ST_CMD, ST_LOC, ST_DATA, ST_ADDRR, ST_RDATA} etw_step_t;
endpackage

// ==== verification/eeprom_two_wire_access_tb.sv ====
// Self-checking bench: host and device joined over the two-wire link.
module eeprom_two_wire_access_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 0, srst = 1, link_clk = 0, link_srst = 1;
  logic cmd_valid = 0, cmd_ready, cmd_read = 0, wr_valid = 0, wr_ready;
  logic rd_valid, done, prog_busy, prog_done;
  logic [7:0] cmd_loc = 8'h00, cmd_len = 8'h00, wr_data = 8'h00, rd_data;
  logic [7:0] rxq[$];  // Bytes returned by reads.
  int n_errors = 0, num_checks = 0, cyc = 0;
  etw_if bus();
  etw_host #(.QTR(48)) etw_host_inst (.clock(clock), .srst(srst), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_loc(cmd_loc), .cmd_len(cmd_len),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid),
    .rd_data(rd_data), .done(done), .bus(bus));
  // Programming outlasts the next command byte, so the refusal path is exercised.
  etw_dev #(.WR_CYCLES(500)) etw_dev_inst (.clock(clock), .srst(srst), .link_clk(link_clk),
    .link_srst(link_srst), .prog_busy(prog_busy), .prog_done(prog_done), .bus(bus));
  etw_asserts #(.WR_CYCLES(500)) etw_asserts_inst (.clock(clock), .srst(srst),
    .link_clk(link_clk), .link_srst(link_srst), .scl(bus.scl), .sda(bus.sda),
    .d_sda_oe(bus.d_sda_oe), .prog_busy(prog_busy), .prog_done(prog_done));
  always #2 clock = ~clock;
  // The link clock starts off phase so the two domains never line up.
  initial begin
    #1.5;
    forever #16 link_clk = ~link_clk;
  end
  always @(posedge clock) begin
    if (rd_valid) rxq.push_back(rd_data);
    cyc++;
    if (cyc == 100000) begin
      n_errors++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One transaction; the host retries refused transactions by itself until done.
  task automatic xfer(input logic rd, input logic [7:0] loc, input logic [7:0] n);
    cmd_valid <= 1'b1;
    cmd_read <= rd;
    cmd_loc <= loc;
    cmd_len <= n;
    @(posedge clock);
    while (!cmd_ready) @(posedge clock);
    cmd_valid <= 1'b0;
    @(posedge clock);
    while (!done) @(posedge clock);
  endtask
  // Fills the FIFO with base + i * step, then writes it at loc.
  task automatic wr(input logic [7:0] loc, input int n, input logic [7:0] base,
                    input logic [7:0] step);
    for (int i = 0; i < n; i++) begin
      wr_valid <= 1'b1;
      wr_data <= base + 8'(i) * step;
      @(posedge clock);
      while (!wr_ready) @(posedge clock);
    end
    wr_valid <= 1'b0;
    xfer(1'b0, loc, 8'(n));
  endtask
  task automatic rd(input logic [7:0] loc, input logic [7:0] e[]);
    rxq.delete();
    xfer(1'b1, loc, 8'(e.size()));
    check(8'(rxq.size()), 8'(e.size()));
    foreach (e[i]) if (i < rxq.size()) check(rxq[i], e[i]);
  endtask
  initial begin
    repeat (8) @(posedge link_clk);
    link_srst <= 1'b0;
    @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    wr(8'h00, 10, 8'h00, 8'h11);
    // Read at once: the command is refused until programming ends.
    check(8'(prog_busy), 8'h01);
    rd(8'h00, '{8'h88, 8'h99, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h77});
    wr(8'h0e, 3, 8'ha0, 8'h01);
    check(8'(prog_busy), 8'h01);
    rd(8'h07, '{8'h77, 8'ha2});
    rd(8'h0e, '{8'ha0, 8'ha1});
    conclude();
  end
endmodule

// ==== verification/etw_asserts.sv ====
// Checker for the two-wire link and the device programming status.
module etw_asserts #(
  parameter int WR_CYCLES = 200  // Programming time in link cycles.
) (
  input logic clock,
  input logic srst,
  input logic link_clk,
  input logic link_srst,
  input logic scl,
  input logic sda,
  input logic d_sda_oe,
  input logic prog_busy,
  input logic prog_done
);
  localparam int BMIN = WR_CYCLES * 8 - 10;  // Eight system cycles per link cycle.
  localparam int BMAX = WR_CYCLES * 8 + 10;  // Slack covers both synchronisers.
  logic        sda_q;     // Data line one cycle ago.
  logic        dq;        // Device data enable one cycle ago.
  logic [3:0]  acks;      // Device drives seen since the last START.
  logic [6:0]  stop_age;  // Cycles since the last STOP, saturating.
  logic [11:0] busy_len;  // Length of the running busy period.
  // Line events are sampled in the system domain; the link is far slower.
  always_ff @(posedge clock) begin
    sda_q <= sda;
    dq    <= d_sda_oe;
    if (srst || (scl && sda_q && !sda)) acks <= 4'h0;
    else if (d_sda_oe && !dq && acks != 4'hf) acks <= acks + 4'h1;
    if (srst || (scl && !sda_q && sda)) stop_age <= 7'h00;
    else if (stop_age != 7'h7f) stop_age <= stop_age + 7'h01;
    busy_len <= prog_busy ? busy_len + 12'h001 : 12'h000;
  end
  a_dev_sda_low: assert property (@(posedge link_clk) disable iff (link_srst)
    $changed(d_sda_oe) |-> !scl) else $error("device moved data while clock high");
  a_dev_drive_ends: assert property (@(posedge link_clk) disable iff (link_srst)
    $rose(d_sda_oe) |-> ##[1:300] !d_sda_oe) else $error("device holds data low");
  a_busy_on_stop: assert property (@(posedge clock) disable iff (srst)
    $rose(prog_busy) |-> stop_age < 7'h64) else $error("programming without stop");
  a_busy_has_data: assert property (@(posedge clock) disable iff (srst)
    $rose(prog_busy) |-> acks >= 4'h4) else $error("programming without data");
  a_busy_length: assert property (@(posedge clock) disable iff (srst)
    $fell(prog_busy) |-> busy_len inside {[BMIN:BMAX]}) else $error("bad busy time");
  a_busy_refuse: assert property (@(posedge clock) disable iff (srst)
    prog_busy && d_sda_oe && !dq |-> acks == 4'h0) else $error("command acked busy");
  a_done_follows: assert property (@(posedge clock) disable iff (srst)
    $fell(prog_busy) |-> ##[0:8] prog_done) else $error("no done after busy");
  a_done_pulse: assert property (@(posedge clock) disable iff (srst)
    prog_done |-> !prog_busy ##1 !prog_done) else $error("bad done pulse");
endmodule
